// File: pkg/pscl_regs.vh
// Constants for the strap configuration latch: offsets, fields and resets.
// Functional notes
// - Copper mode: speed strap high means 100 Mb/s, low means 10 Mb/s; default high.
// - Sampled speed goes to control bit 13 and advertisement speed capability bits.
// - Shared speed pin is the speed strap only when fiber mode select is 0.
// - Fiber mode: shared pin is far-end-fault strap, high enables; default high.
// - Far-end-fault strap captured only at reset, held afterwards.
// - Duplex strap high means half duplex, low full duplex; default high.
// - Sampled duplex strap loads control register bit 8.
// - Autoneg strap high enables auto-negotiation, low disables; default high.
// - Sampled autoneg strap loads control register bit 12.
// - Fiber mode forces auto-negotiation disabled whatever the autoneg strap says.
// - Pull-up strap pins are inputs only during reset, outputs otherwise.
// - Pull-down strap pins are inputs only during reset, outputs otherwise.
`ifndef PSCL_REGS_VH
`define PSCL_REGS_VH
`define PSCL_ADR_CTRL       4'h0
`define PSCL_ADR_ADV        4'h4
`define PSCL_ADR_STRAP      4'h8
`define PSCL_ADR_PINOUT     4'hc
`define PSCL_CTRL_DUPLEX    8
`define PSCL_CTRL_ANEN      12
`define PSCL_CTRL_SPEED     13
`define PSCL_ADV_10HD       5
`define PSCL_ADV_10FD       6
`define PSCL_ADV_100HD      7
`define PSCL_ADV_100FD      8
`define PSCL_ST_SPEED       0
`define PSCL_ST_DUPLEX      1
`define PSCL_ST_ANEN        2
`define PSCL_ST_FEF         3
`define PSCL_ST_FIBER       4
`define PSCL_CTRL_RST       16'h3100
`define PSCL_ADV_RST        16'h01e1
`define PSCL_ADV_SEL        16'h0001
`endif

// File: src/pscl_pin_cell.v
// Strap pin cell: input during reset, output driven by the block afterwards.
`timescale 1ns/10ps
`include "pscl_regs.vh"
module pscl_pin_cell (
	input  wire clk_i,
	input  wire rst_i,
	input  wire out_val_i,
	output reg  pin_o,
	output reg  pin_oe_n_o
);
	// The enable is held released while reset is high so the pull and board win.
	always @(posedge clk_i) begin
		pin_oe_n_o <= rst_i;
		pin_o      <= rst_i ? 1'b0 : out_val_i;
	end
endmodule // pscl_pin_cell

// File: src/pscl_capture.v
// Strap capture: decodes pin levels into configuration at reset release.
`timescale 1ns/10ps
`include "pscl_regs.vh"
module pscl_capture (
	input  wire clk_i,
	input  wire rst_i,
	input  wire speed_pin_i,
	input  wire duplex_pin_i,
	input  wire anen_pin_i,
	input  wire fiber_mode_select_i,
	output reg  load_o,
	output reg  speed_100_o,
	output reg  half_duplex_o,
	output reg  autoneg_en_o,
	output reg  far_end_fault_o,
	output reg  fiber_o
);
	reg rst_d_reg;
	always @(posedge clk_i) begin
		rst_d_reg <= rst_i;
		load_o    <= 1'b0;
		if (rst_i) begin
			// Pull-up defaults stand until the first sample.
			speed_100_o     <= 1'b1;
			half_duplex_o   <= 1'b1;
			autoneg_en_o    <= 1'b1;
			far_end_fault_o <= 1'b1;
			fiber_o         <= 1'b0;
		end else if (rst_d_reg) begin
			// Sampled once, on the first edge after release; never again.
			load_o          <= 1'b1;
			fiber_o         <= fiber_mode_select_i;
			speed_100_o     <= fiber_mode_select_i ? 1'b1 : speed_pin_i;
			far_end_fault_o <= fiber_mode_select_i ? speed_pin_i : 1'b0;
			half_duplex_o   <= duplex_pin_i;
			autoneg_en_o    <= anen_pin_i & ~fiber_mode_select_i;
		end
	end
endmodule // pscl_capture

// File: src/pscl_top.v
// Strap configuration latch with Wishbone access to control and advertisement.
`timescale 1ns/10ps
`include "pscl_regs.vh"
module pscl_top (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        fiber_mode_select_i,
	input  wire        speed_pin_i,
	output wire        speed_pin_o,
	output wire        speed_pin_oe_n_o,
	input  wire        duplex_pin_i,
	output wire        duplex_pin_o,
	output wire        duplex_pin_oe_n_o,
	input  wire        anen_pin_i,
	output wire        anen_pin_o,
	output wire        anen_pin_oe_n_o,
	output wire        far_end_fault_o
);
	reg  [15:0] ctrl_reg;
	reg  [15:0] adv_reg;
	reg  [2:0]  pinout_reg;
	wire        load;
	wire        s_speed;
	wire        s_half;
	wire        s_anen;
	wire        s_fef;
	wire        s_fiber;

	pscl_capture u_cap (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.speed_pin_i        (speed_pin_i),
		.duplex_pin_i       (duplex_pin_i),
		.anen_pin_i         (anen_pin_i),
		.fiber_mode_select_i(fiber_mode_select_i),
		.load_o             (load),
		.speed_100_o        (s_speed),
		.half_duplex_o      (s_half),
		.autoneg_en_o       (s_anen),
		.far_end_fault_o    (s_fef),
		.fiber_o            (s_fiber)
	);

	assign far_end_fault_o = s_fef;

	// After reset the shared pins become outputs carrying the pinout register.
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_pin
			wire po;
			wire pe;
			pscl_pin_cell u_pin (
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.out_val_i (pinout_reg[g]),
				.pin_o     (po),
				.pin_oe_n_o(pe)
			);
			if (g == 0) begin : g_s
				assign speed_pin_o      = po;
				assign speed_pin_oe_n_o = pe;
			end else if (g == 1) begin : g_d
				assign duplex_pin_o      = po;
				assign duplex_pin_oe_n_o = pe;
			end else begin : g_a
				assign anen_pin_o      = po;
				assign anen_pin_oe_n_o = pe;
			end
		end
	endgenerate

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] dat;
		input [3:0]  sel;
		begin
			merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
		end
	endfunction

	wire req;
	wire wr;
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// The write lands at the edge where the master sees ack, while its data is still held.
	assign wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg   <= `PSCL_CTRL_RST;
			adv_reg    <= `PSCL_ADV_RST;
			pinout_reg <= 3'h0;
		end else if (load) begin
			ctrl_reg[`PSCL_CTRL_SPEED]  <= s_speed;
			ctrl_reg[`PSCL_CTRL_ANEN]   <= s_anen;
			ctrl_reg[`PSCL_CTRL_DUPLEX] <= ~s_half;
			// Only the capabilities the strapped speed allows are advertised.
			adv_reg <= `PSCL_ADV_SEL | (16'h0001 << `PSCL_ADV_10HD)
				| (16'h0001 << `PSCL_ADV_10FD)
				| ({15'h0, s_speed} << `PSCL_ADV_100HD)
				| ({15'h0, s_speed} << `PSCL_ADV_100FD);
		end else if (wr) begin
			// Strap-loaded control and advertisement bits stay writable afterwards.
			case (wb_adr_i)
			`PSCL_ADR_CTRL: begin
				ctrl_reg <= merge16(ctrl_reg, wb_dat_i, wb_sel_i);
			end
			`PSCL_ADR_ADV: begin
				adv_reg <= merge16(adv_reg, wb_dat_i, wb_sel_i);
			end
			`PSCL_ADR_PINOUT: begin
				if (wb_sel_i[0])
					pinout_reg <= wb_dat_i[2:0];
			end
			default: begin
			end
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			case (wb_adr_i)
			`PSCL_ADR_CTRL:   wb_dat_o <= {16'h0000, ctrl_reg};
			`PSCL_ADR_ADV:    wb_dat_o <= {16'h0000, adv_reg};
			`PSCL_ADR_STRAP:  wb_dat_o <= {27'h0, s_fiber, s_fef, s_anen, ~s_half, s_speed};
			`PSCL_ADR_PINOUT: wb_dat_o <= {29'h0, pinout_reg};
			default:          wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule // pscl_top

// File: verification/pscl_props_properties.sv
// Checker for the strap configuration latch ports.
`timescale 1ns/10ps
module pscl_props (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [3:0]  wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        fiber_mode_select_i,
	input wire        speed_pin_i,
	input wire        speed_pin_oe_n_o,
	input wire        duplex_pin_oe_n_o,
	input wire        anen_pin_oe_n_o,
	input wire        far_end_fault_o
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire [2:0] oe_n = {anen_pin_oe_n_o, duplex_pin_oe_n_o, speed_pin_oe_n_o};
	reg        fef_smp;
	// The strap is only valid on the release edge, so it is kept here for the later check.
	always @(posedge clk_i)
		if ($fell(rst_i))
			fef_smp <= fiber_mode_select_i && speed_pin_i;
	sequence s_load;
		$fell(rst_i) ##2 1'b1;
	endsequence
	chk_oe_reset: assert property ($fell(rst_i) |-> oe_n == 3'h7)
		else $error("strap pins driven during reset");
	chk_oe_drive: assert property (!rst_i [*4] |-> oe_n == 3'h0)
		else $error("strap pins not driven after reset");
	chk_fef_load: assert property (s_load |-> far_end_fault_o == fef_smp)
		else $error("far end fault not loaded from strap");
	chk_fef_hold: assert property (!rst_i [*4] |-> $stable(far_end_fault_o))
		else $error("far end fault changed after load");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
		|-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper read bits not zero");
endmodule // pscl_props
bind pscl_top pscl_props i_pscl_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .fiber_mode_select_i, .speed_pin_i, .speed_pin_oe_n_o,
	.duplex_pin_oe_n_o, .anen_pin_oe_n_o, .far_end_fault_o);

// File: verification/pscl_board.sv
// Board model: strap resistors on the shared pins and the resolved wire level.
`timescale 1ns/10ps
module pscl_board (
	input  wire [2:0] strap_i,
	input  wire [2:0] drv_i,
	input  wire [2:0] oe_n_i,
	output wire [2:0] pin_o
);
	// No receive input drives the pins in reset, so only the resistor level is seen.
	assign pin_o = (oe_n_i & strap_i) | (~oe_n_i & drv_i);
endmodule // pscl_board

// File: verification/pscl_top_bench.sv
// Self-checking bench for the strap configuration latch.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module pscl_top_bench;
	reg        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fx = 0;
	reg [3:0]  adr = 0, sel = 4'h3;
	reg [31:0] wdat = 0, q;
	reg [2:0]  strap = 3'h7;
	wire [31:0] rdat;
	wire       ack, fef;
	wire [2:0] drv, oe_n, pins;
	integer    n_fail = 0, n_tests = 0, i, sp, an, fu, r;
	pscl_top i_pscl_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .fiber_mode_select_i(fx), .speed_pin_i(pins[0]),
		.speed_pin_o(drv[0]), .speed_pin_oe_n_o(oe_n[0]), .duplex_pin_i(pins[1]),
		.duplex_pin_o(drv[1]), .duplex_pin_oe_n_o(oe_n[1]), .anen_pin_i(pins[2]),
		.anen_pin_o(drv[2]), .anen_pin_oe_n_o(oe_n[2]), .far_end_fault_o(fef));
	pscl_board i_pscl_board (.strap_i(strap), .drv_i(drv), .oe_n_i(oe_n), .pin_o(pins));
	initial forever #5 clk_i = ~clk_i;
	task bus(input [3:0] a, input w, input [31:0] d, input [3:0] s);
		begin
			@(posedge clk_i);
			cyc <= 1;
			stb <= 1;
			we <= w;
			adr <= a;
			sel <= s;
			wdat <= d;
			@(posedge clk_i);
			while (ack !== 1'b1) @(posedge clk_i);
			q = rdat;
			cyc <= 0;
			stb <= 0;
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", n_tests, n_fail);
			if (n_fail == 0 && n_tests > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	initial begin
		r = $urandom(32'h7c413ac2);
		for (i = 0; i < 16; i++) begin
			rst_i <= 1;
			fx <= i[3];
			strap <= i[2:0];
			repeat (8) @(posedge clk_i);
			rst_i <= 0;
			repeat (2) @(posedge clk_i);
			sp = i[3] | i[0];
			an = !i[3] & i[2];
			fu = !i[1];
			bus(4'h0, 0, 0, 4'h3);
			`CHK("ctrl", sp << 13 | an << 12 | fu << 8, q)
			bus(4'h4, 0, 0, 4'h3);
			`CHK("adv", 32'h61 | (sp ? 32'h180 : 0), q)
			// Flipping the mode after release must not reach the captured settings.
			r = $urandom;
			fx <= !fx;
			bus(4'hc, 1, r, 4'h3);
			// The pin drive is registered once more behind the pinout register.
			repeat (2) @(negedge clk_i);
			`CHK("pins", r[2:0], pins)
			bus(4'hc, 0, 0, 4'h3);
			`CHK("pinout", r[2:0], q)
			bus(4'h0, 1, r, 4'h3);
			bus(4'h0, 1, ~r, 4'h2);
			bus(4'h0, 0, 0, 4'h3);
			`CHK("ctrl_wr", {16'h0000, ~r[15:8], r[7:0]}, q)
			bus(4'h8, 0, 0, 4'h3);
			`CHK("strap", {i[3], i[3] & i[0], an[0], fu[0], sp[0]}, q)
			`CHK("fef", i[3] & i[0], fef)
			bus(4'h2, 0, 0, 4'h3);
			`CHK("unmapped", 0, q)
		end
		print_verdict;
	end
	initial begin
		#100000;
		n_fail++;
		print_verdict;
	end
endmodule // pscl_top_bench
